// ===== verilog/lss_cfg.svh
// timing, level and layout constants for the list step sequencer
`ifndef LSS_CFG_SVH
`define LSS_CFG_SVH

// clock and mains timing
`define LSS_CLK_PERIOD_NS      40
`define LSS_LINE_PERIOD_NS     20000000
`define LSS_LINE_CYCLES        (`LSS_LINE_PERIOD_NS / `LSS_CLK_PERIOD_NS)

// list storage layout
`define LSS_LIST_FIRST         4'h1
`define LSS_LIST_LAST          4'h9
`define LSS_LIST_DEMO          4'h0
`define LSS_POINTS             16
`define LSS_SLOTS              144

// return-to-zero levels: 0 mV and 100 mA
`define LSS_ENDZ_VOLT          16'h0000
`define LSS_ENDZ_CURR          16'h0064

// built-in demonstration list
`define LSS_DEMO_LEN           5'h04
`define LSS_DEMO_VSTEP         16'h03e8
`define LSS_DEMO_CURR          16'h01f4
`define LSS_DEMO_DWELL         24'h00c350

`endif

// ===== verilog/lss_pkg.sv
// types shared by the list step sequencer
package lss_pkg;

    // source level of one list point: millivolts and milliamps
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
    } lss_level_s;

    // one stored list point; dwell counted in clock cycles
    typedef struct packed {
        lss_level_s  level;
        logic [23:0] dwell;
    } lss_step_s;

    // trigger source of the trigger layer
    typedef enum logic [1:0] {
        LSS_TRIG_IMM = 2'h0,
        LSS_TRIG_EXT = 2'h1,
        LSS_TRIG_BUS = 2'h2,
        LSS_TRIG_MAN = 2'h3
    } lss_trig_e;

    // sequencer states, gray coded along the step path
    typedef enum logic [2:0] {
        LSS_IDLE    = 3'h0,
        LSS_SOURCE  = 3'h1,
        LSS_DELAY   = 3'h3,
        LSS_MEASURE = 3'h2,
        LSS_STEPEND = 3'h6,
        LSS_WAIT    = 3'h7,
        LSS_FINISH  = 3'h5
    } lss_state_e;

endpackage

// ===== verilog/lss_sample_timer.sv
// sample pacing timer: one tick per sample period while enabled
`timescale 1ns/1ps
`default_nettype none

module lss_sample_timer (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        en,
    input  wire logic [31:0] period,
    // sample tick
    output logic             tick
);

    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        next_tick;

    // count up to the period, restart whenever disabled
    always_comb
    begin
        next_cnt  = 32'h0;
        next_tick = 1'b0;
        if (en)
        begin
            if (cnt + 32'h1 >= period)
            begin
                next_tick = 1'b1;
            end
            else
            begin
                next_cnt = cnt + 32'h1;
            end
        end
    end

    // register counter and tick
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule // lss_sample_timer

`default_nettype wire

// ===== verilog/lss_list_step_sequencer.sv
// list step sequencer: runs a stored source list per trigger
//
// Functional notes
// - list index 1..9, demo list by default
// - time hold: step lasts until dwell expires
// - point hold: step lasts until sample count
// - end zero on: finish at 0 V, 0.1 A
// - end zero off: keep last step levels
// - step mode: one step per trigger, complete each
// - sweep mode: whole list, complete per cycle
// - repeat list for programmed cycle count
// - output off aborts running list at once
// - local start forces trigger layer settings
// - after finish idle; manual trigger restarts list
// - time hold: measure dwell minus delay
// - point hold: samples times period, dwell ignored
// - measure complete driven on digital line 2
// - immediate trigger: next step follows directly
// - other triggers: wait complete then trigger in
// - triggers during a step are discarded
// - autozero lengthens every reading
`timescale 1ns/1ps
`default_nettype none

`include "lss_cfg.svh"

module lss_list_step_sequencer
    import lss_pkg::*;
#(
    parameter int unsigned LINE_CYCLES = `LSS_LINE_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // list storage write port
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_list,
    input  wire logic [3:0]  wr_point,
    input  wire logic        wr_last,
    input  wire lss_step_s   wr_step,
    // configuration
    input  wire logic [3:0]  list_sel,
    input  wire logic        hold_point,
    input  wire logic        end_zero,
    input  wire logic        sweep_mode,
    input  wire logic [7:0]  cycle_count,
    input  wire lss_trig_e   trig_src,
    input  wire logic [23:0] src_delay,
    input  wire logic [15:0] sample_count,
    input  wire logic [3:0]  integration_line_cycles,
    input  wire logic        autozero,
    // control and trigger events
    input  wire logic        start_local,
    input  wire logic        start_remote,
    input  wire logic        manual_trig,
    input  wire logic        bus_trig,
    input  wire logic        trig_in_pin,
    input  wire logic        output_on,
    // source and status
    output lss_level_s       src,
    output logic             running,
    output logic             measuring,
    output logic             dio2_out,
    output logic             sample_strobe,
    output logic [3:0]       step_idx,
    output logic [7:0]       cycle_idx,
    output logic [15:0]      samples_taken,
    // trigger layer settings in force
    output lss_trig_e        trig_src_eff,
    output logic [4:0]       trig_count,
    output logic [7:0]       arm_count,
    output logic             init_cont
);

    // list storage, no reset needed for data
    lss_step_s   mem [0:`LSS_SLOTS-1];
    logic [4:0]  len [1:9];

    // state
    lss_state_e  state;
    lss_state_e  next_state;
    logic [3:0]  list_q;
    logic [3:0]  next_list_q;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [31:0] sample_period;
    logic [31:0] next_sample_period;
    lss_level_s  next_src;
    logic        next_running;
    logic        next_dio2;
    logic [3:0]  next_step_idx;
    logic [7:0]  next_cycle_idx;
    logic [15:0] next_samples;
    lss_trig_e   next_trig_src_eff;
    logic [4:0]  next_trig_count;
    logic [7:0]  next_arm_count;
    logic        next_init_cont;

    // trigger pin synchroniser
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_s3;
    logic        trig_lvl;
    logic        next_trig_lvl;
    logic        trig_edge;

    // combinational helpers
    lss_step_s   cur_step;
    logic [4:0]  cur_len;
    logic [4:0]  sel_len;
    logic [3:0]  sel_list;
    logic        tick;
    logic        last_step;
    logic        last_cycle;
    logic        trig_ok;
    logic [31:0] meas_len;

    // demo list is generated, not stored
    function automatic lss_step_s demo_step(input logic [3:0] p);
        lss_step_s s;
        s.level.volt = 16'((p + 4'h1) * `LSS_DEMO_VSTEP);
        s.level.curr = `LSS_DEMO_CURR;
        s.dwell      = `LSS_DEMO_DWELL;
        return s;
    endfunction

    // list storage write; the point written with wr_last sets the length
    always_ff @(posedge ref_clk)
    begin
        if (wr_en && wr_list >= `LSS_LIST_FIRST && wr_list <= `LSS_LIST_LAST)
        begin
            mem[(8'(wr_list) - 8'h1) * 8'h10 + 8'(wr_point)] <= wr_step;
            if (wr_last)
            begin
                len[wr_list] <= 5'(wr_point) + 5'h1;
            end
        end
    end

    // select stored list 1..9, anything else runs the demo
    always_comb
    begin
        sel_list = `LSS_LIST_DEMO;
        sel_len  = `LSS_DEMO_LEN;
        if (list_sel >= `LSS_LIST_FIRST && list_sel <= `LSS_LIST_LAST)
        begin
            sel_list = list_sel;
            sel_len  = len[list_sel];
        end
        if (sel_len == 5'h0)
        begin
            sel_len = 5'h1;
        end
        cur_step = demo_step(step_idx);
        if (list_q != `LSS_LIST_DEMO)
        begin
            cur_step = mem[(8'(list_q) - 8'h1) * 8'h10 + 8'(step_idx)];
        end
    end

    // three-stage pin synchroniser; an edge counts once the last two stages agree
    always_comb
    begin
        next_trig_lvl = trig_lvl;
        if (trig_s2 == trig_s3)
        begin
            next_trig_lvl = trig_s3;
        end
        trig_edge = (trig_s2 == trig_s3) && trig_s3 && !trig_lvl;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            trig_s1  <= 1'b0;
            trig_s2  <= 1'b0;
            trig_s3  <= 1'b0;
            trig_lvl <= 1'b0;
        end
        else
        begin
            trig_s1  <= trig_in_pin;
            trig_s2  <= trig_s1;
            trig_s3  <= trig_s2;
            trig_lvl <= next_trig_lvl;
        end
    end

    // sample pacing for the measure phase
    lss_sample_timer u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .en      (state == LSS_MEASURE),
        .period  (sample_period),
        .tick    (tick)
    );

    // step status and trigger acceptance for the source in force
    always_comb
    begin
        cur_len    = trig_count;
        last_step  = (5'(step_idx) + 5'h1 >= cur_len);
        last_cycle = (cycle_idx + 8'h1 >= arm_count);
        case (trig_src_eff)
            LSS_TRIG_EXT: trig_ok = trig_edge;
            LSS_TRIG_BUS: trig_ok = bus_trig;
            LSS_TRIG_MAN: trig_ok = manual_trig;
            default:      trig_ok = 1'b1;
        endcase
        meas_len = 32'h1;
        if (cur_step.dwell > src_delay)
        begin
            meas_len = 32'(cur_step.dwell - src_delay);
        end
    end

    // sequencer next state
    always_comb
    begin
        next_state         = state;
        next_list_q        = list_q;
        next_cnt           = cnt;
        next_src           = src;
        next_running       = running;
        next_dio2          = 1'b0;
        next_step_idx      = step_idx;
        next_cycle_idx     = cycle_idx;
        next_samples       = samples_taken;
        next_trig_src_eff  = trig_src_eff;
        next_trig_count    = trig_count;
        next_arm_count     = arm_count;
        next_init_cont     = init_cont;
        // autozero takes a reference and a zero reading each sample
        next_sample_period = 32'(integration_line_cycles) * LINE_CYCLES;
        if (autozero)
        begin
            next_sample_period = next_sample_period * 32'h3;
        end
        if (next_sample_period == 32'h0)
        begin
            next_sample_period = 32'h1;
        end
        case (state)
            LSS_IDLE:
            begin
                if (output_on && (start_local || start_remote || manual_trig))
                begin
                    next_list_q     = sel_list;
                    next_trig_count = sel_len;
                    next_arm_count  = (cycle_count == 8'h0) ? 8'h1 : cycle_count;
                    next_init_cont  = 1'b0;
                    next_trig_src_eff = trig_src;
                    if (start_local)
                    begin
                        next_trig_src_eff = LSS_TRIG_IMM;
                    end
                    next_step_idx  = 4'h0;
                    next_cycle_idx = 8'h0;
                    next_running   = 1'b1;
                    next_state     = LSS_SOURCE;
                end
            end
            LSS_SOURCE:
            begin
                next_src     = cur_step.level;
                next_cnt     = 32'h0;
                next_samples = 16'h0;
                next_state   = (src_delay == 24'h0) ? LSS_MEASURE : LSS_DELAY;
            end
            LSS_DELAY:
            begin
                next_cnt = cnt + 32'h1;
                if (cnt + 32'h1 >= 32'(src_delay))
                begin
                    next_cnt   = 32'h0;
                    next_state = LSS_MEASURE;
                end
            end
            LSS_MEASURE:
            begin
                next_cnt = cnt + 32'h1;
                if (tick)
                begin
                    next_samples = samples_taken + 16'h1;
                end
                if (hold_point)
                begin
                    // dwell is ignored in point hold
                    if (tick && samples_taken + 16'h1 >= sample_count)
                    begin
                        next_state = LSS_STEPEND;
                    end
                end
                else if (cnt + 32'h1 >= meas_len)
                begin
                    next_state = LSS_STEPEND;
                end
            end
            LSS_STEPEND:
            begin
                // in time hold a sample that ends with the dwell still counts
                if (tick && !hold_point)
                begin
                    next_samples = samples_taken + 16'h1;
                end
                // complete after every step, or once per list cycle
                next_dio2 = !sweep_mode || last_step;
                if (last_step)
                begin
                    next_step_idx  = 4'h0;
                    next_cycle_idx = cycle_idx + 8'h1;
                end
                else
                begin
                    next_step_idx = step_idx + 4'h1;
                end
                if (last_step && last_cycle)
                begin
                    next_state = LSS_FINISH;
                end
                else if (trig_src_eff == LSS_TRIG_IMM)
                begin
                    next_state = LSS_SOURCE;
                end
                else if (!sweep_mode || last_step)
                begin
                    next_state = LSS_WAIT;
                end
                else
                begin
                    next_state = LSS_SOURCE;
                end
            end
            LSS_WAIT:
            begin
                // only here is a trigger taken; earlier ones are dropped
                if (trig_ok)
                begin
                    next_state = LSS_SOURCE;
                end
            end
            LSS_FINISH:
            begin
                if (end_zero)
                begin
                    next_src.volt = `LSS_ENDZ_VOLT;
                    next_src.curr = `LSS_ENDZ_CURR;
                end
                // otherwise the last step levels stay
                next_running = 1'b0;
                next_state   = LSS_IDLE;
            end
            default:
            begin
                next_running = 1'b0;
                next_state   = LSS_IDLE;
            end
        endcase
        if (!output_on && state != LSS_IDLE)
        begin
            next_running = 1'b0;
            next_dio2    = 1'b0;
            next_state   = LSS_IDLE;
        end
    end

    // sequencer registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state         <= LSS_IDLE;
            list_q        <= `LSS_LIST_DEMO;
            cnt           <= 32'h0;
            sample_period <= 32'h1;
            src           <= '0;
            running       <= 1'b0;
            measuring     <= 1'b0;
            dio2_out      <= 1'b0;
            sample_strobe <= 1'b0;
            step_idx      <= 4'h0;
            cycle_idx     <= 8'h0;
            samples_taken <= 16'h0;
            trig_src_eff  <= LSS_TRIG_IMM;
            trig_count    <= 5'h1;
            arm_count     <= 8'h1;
            init_cont     <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            list_q        <= next_list_q;
            cnt           <= next_cnt;
            sample_period <= next_sample_period;
            src           <= next_src;
            running       <= next_running;
            measuring     <= (next_state == LSS_MEASURE);
            dio2_out      <= next_dio2;
            sample_strobe <= tick;
            step_idx      <= next_step_idx;
            cycle_idx     <= next_cycle_idx;
            samples_taken <= next_samples;
            trig_src_eff  <= next_trig_src_eff;
            trig_count    <= next_trig_count;
            arm_count     <= next_arm_count;
            init_cont     <= next_init_cont;
        end
    end

endmodule // lss_list_step_sequencer

`default_nettype wire

// ===== dv/lss_seq_props.sv
// concurrent checks on the list step sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "lss_cfg.svh"

module lss_seq_props
    import lss_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // watched inputs
    input wire logic       output_on,
    input wire logic       start_local,
    input wire logic       end_zero,
    // watched outputs
    input wire lss_level_s src,
    input wire logic       running,
    input wire logic       measuring,
    input wire logic       dio2_out,
    input wire logic [3:0] step_idx,
    input wire logic [7:0] cycle_idx,
    input wire lss_trig_e  trig_src_eff,
    input wire logic [4:0] trig_count,
    input wire logic [7:0] arm_count,
    input wire logic       init_cont
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // property set, one per rule
    property p_abort; running && !output_on |=> !running; endproperty
    a_abort: assert property (p_abort) else $error("run kept after output off");
    property p_pulse; dio2_out |=> !dio2_out; endproperty
    a_pulse: assert property (p_pulse) else $error("complete pulse too long");
    property p_dio_meas; dio2_out |-> !measuring; endproperty
    a_dio_meas: assert property (p_dio_meas) else $error("complete during measure");
    property p_rz;
        $fell(running) && output_on && end_zero |-> ##[0:1]
            src == {`LSS_ENDZ_VOLT, `LSS_ENDZ_CURR};
    endproperty
    a_rz: assert property (p_rz) else $error("end level not zeroed");
    property p_local;
        $rose(running) && $past(start_local) |->
            trig_src_eff == LSS_TRIG_IMM && !init_cont && arm_count != 8'h00;
    endproperty
    a_local: assert property (p_local) else $error("local start settings wrong");
    property p_order; $rose(running) |-> !measuring [*2]; endproperty
    a_order: assert property (p_order) else $error("measure before source");
    property p_srcstab; measuring && $past(measuring) |-> $stable(src); endproperty
    a_srcstab: assert property (p_srcstab) else $error("level moved in measure");
    property p_idx; running |-> {1'b0, step_idx} <= trig_count; endproperty
    a_idx: assert property (p_idx) else $error("step index past list");
    property p_cyc; running |-> cycle_idx <= arm_count; endproperty
    a_cyc: assert property (p_cyc) else $error("cycle index past count");
endmodule // lss_seq_props

`default_nettype wire

// ===== dv/lss_trig_partner.sv
// far side model: external trigger source and digital line 2 observer
`timescale 1ns/1ps
`default_nettype none

module lss_trig_partner (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // bench controls
    input  wire logic auto_trig,
    input  wire logic kick,
    // device side
    input  wire logic dio2_out,
    output logic      trig_in_pin,
    output int        dio_n
);
    int wait_n;

    // count complete pulses, fire a two-cycle trigger on kick or, with auto_trig set, after a pulse
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dio_n <= 0;
            wait_n <= 0;
            trig_in_pin <= 1'b0;
        end
        else
        begin
            dio_n <= dio_n + int'(dio2_out);
            if (kick)
                wait_n <= 2;
            else if (dio2_out && auto_trig)
                wait_n <= 5;
            else if (wait_n != 0)
                wait_n <= wait_n - 1;
            trig_in_pin <= (wait_n == 1) || (wait_n == 2);
        end
    end
endmodule // lss_trig_partner

`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the list step sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lss_pkg::*;
    logic        ref_clk, rst_n, wr_en, wr_last, hold_point, end_zero, sweep_mode;
    logic        autozero, start_local, start_remote, manual_trig, bus_trig;
    logic        trig_in_pin, output_on, running, measuring, dio2_out, sample_strobe;
    logic        init_cont, auto_trig, kick;
    logic [3:0]  wr_list, wr_point, list_sel, integration_line_cycles, step_idx;
    logic [7:0]  cycle_count, cycle_idx, arm_count;
    logic [15:0] sample_count, samples_taken;
    logic [23:0] src_delay;
    logic [4:0]  trig_count;
    lss_step_s   wr_step;
    lss_trig_e   trig_src, trig_src_eff;
    lss_level_s  src;
    int          err_count, check_count, n_smp, n_meas, dio_n, b;

    lss_list_step_sequencer #(.LINE_CYCLES(4)) u_dut (.ref_clk, .rst_n, .wr_en, .wr_list,
        .wr_point, .wr_last, .wr_step, .list_sel, .hold_point, .end_zero, .sweep_mode,
        .cycle_count, .trig_src, .src_delay, .sample_count, .integration_line_cycles,
        .autozero, .start_local, .start_remote, .manual_trig, .bus_trig, .trig_in_pin,
        .output_on, .src, .running, .measuring, .dio2_out, .sample_strobe, .step_idx,
        .cycle_idx, .samples_taken, .trig_src_eff, .trig_count, .arm_count, .init_cont);
    lss_trig_partner u_far (.ref_clk, .rst_n, .auto_trig, .kick, .dio2_out,
        .trig_in_pin, .dio_n);

    // 25 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // samples taken and measure length of the current run
    always @(posedge ref_clk)
    begin
        n_smp += int'(sample_strobe);
        n_meas += int'(measuring);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_sig(ref logic s, input logic v);
        for (int i = 0; i < 3000 && s !== v; i++)
            tick(1);
        chk(s, v);
    endtask

    task automatic wr_pt(input logic [3:0] l, p, input logic last,
                         input logic [15:0] v, input logic [23:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        wr_list <= l;
        wr_point <= p;
        wr_last <= last;
        wr_step <= {v, 16'h0032, d};
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task automatic go(input int k);
        @(posedge ref_clk);
        start_local <= (k == 0);
        start_remote <= (k == 1);
        manual_trig <= (k == 2);
        @(posedge ref_clk);
        {start_local, start_remote, manual_trig} <= 3'h0;
        #1;
        n_smp = 0;
        n_meas = 0;
        b = dio_n;
    endtask

    task automatic pulse_kick;
        @(posedge ref_clk);
        kick <= 1'b1;
        @(posedge ref_clk);
        kick <= 1'b0;
    endtask

    // watchdog
    initial
    begin
        #(40 * 30000);
        err_count++;
        end_of_test();
    end

    // main sequence
    initial
    begin
        {rst_n, wr_en, wr_last, hold_point, end_zero, sweep_mode, autozero} = 7'h00;
        {start_local, start_remote, manual_trig, bus_trig, auto_trig, kick} = 6'h00;
        {wr_list, wr_point, list_sel, cycle_count} = 20'h0;
        wr_step = '0;
        trig_src = LSS_TRIG_EXT;
        src_delay = 24'h000002;
        sample_count = 16'h0003;
        integration_line_cycles = 4'h1;
        output_on = 1'b1;
        tick(20);
        chk(trig_count, 32'h1);
        chk(arm_count, 32'h1);
        chk(running, 32'h0);
        rst_n <= 1'b1;
        wr_pt(4'h1, 4'h0, 1'b0, 16'h0064, 24'h000014);
        wr_pt(4'h1, 4'h1, 1'b0, 16'h00c8, 24'h000014);
        wr_pt(4'h1, 4'h2, 1'b1, 16'h012c, 24'h000014);
        wr_pt(4'h2, 4'h0, 1'b1, 16'h02bc, 24'h00001e);
        wr_pt(4'h0, 4'h0, 1'b1, 16'h0fff, 24'h000001);
        // local start: forced settings, every step completes, end at zero
        list_sel <= 4'h1;
        cycle_count <= 8'h02;
        end_zero <= 1'b1;
        go(0);
        chk(trig_src_eff, LSS_TRIG_IMM);
        chk(trig_count, 32'h3);
        chk(arm_count, 32'h2);
        chk(init_cont, 32'h0);
        wait_sig(running, 1'b0);
        tick(2);
        chk(dio_n - b, 32'h6);
        chk(src, {16'h0000, 16'h0064});
        // external triggers: stray ones dropped, each step waits
        end_zero <= 1'b0;
        cycle_count <= 8'h01;
        go(1);
        pulse_kick();
        wait_sig(measuring, 1'b1);
        pulse_kick();
        wait_sig(dio2_out, 1'b1);
        tick(40);
        chk(dio_n - b, 32'h1);
        chk(running, 32'h1);
        auto_trig <= 1'b1;
        pulse_kick();
        wait_sig(running, 1'b0);
        tick(2);
        chk(dio_n - b, 32'h3);
        chk(src, {16'h012c, 16'h0032});
        auto_trig <= 1'b0;
        // sweep: one complete per list cycle
        sweep_mode <= 1'b1;
        cycle_count <= 8'h02;
        tick(10);
        go(0);
        wait_sig(running, 1'b0);
        tick(2);
        chk(dio_n - b, 32'h2);
        // time hold, point hold, autozero
        sweep_mode <= 1'b0;
        list_sel <= 4'h2;
        cycle_count <= 8'h01;
        go(0);
        wait_sig(running, 1'b0);
        chk((n_meas >= 27) && (n_meas <= 29), 32'h1);
        chk(n_smp, 32'h7);
        chk(samples_taken, 32'h7);
        hold_point <= 1'b1;
        go(0);
        wait_sig(running, 1'b0);
        chk(n_smp, 32'h3);
        chk(samples_taken, 32'h3);
        chk((n_meas >= 11) && (n_meas <= 13), 32'h1);
        autozero <= 1'b1;
        go(0);
        wait_sig(running, 1'b0);
        chk(n_smp, 32'h3);
        chk((n_meas >= 34) && (n_meas <= 38), 32'h1);
        // output off aborts and blocks a start
        {hold_point, autozero} <= 2'h0;
        list_sel <= 4'h1;
        cycle_count <= 8'h03;
        go(0);
        wait_sig(measuring, 1'b1);
        @(posedge ref_clk);
        output_on <= 1'b0;
        tick(1);
        chk(running, 32'h0);
        go(0);
        chk(running, 32'h0);
        output_on <= 1'b1;
        // manual request restarts from the first step
        trig_src <= LSS_TRIG_IMM;
        cycle_count <= 8'h01;
        go(2);
        chk(running, 32'h1);
        chk(step_idx, 32'h0);
        wait_sig(running, 1'b0);
        // bus source: each bus trigger releases one step
        trig_src <= LSS_TRIG_BUS;
        go(1);
        repeat (2)
        begin
            wait_sig(dio2_out, 1'b1);
            @(posedge ref_clk);
            bus_trig <= 1'b1;
            @(posedge ref_clk);
            bus_trig <= 1'b0;
        end
        wait_sig(running, 1'b0);
        chk(dio_n - b, 32'h3);
        // demo list by default
        list_sel <= 4'h0;
        go(0);
        chk(trig_count, 32'h4);
        tick(3);
        chk(src, {16'h03e8, 16'h01f4});
        @(posedge ref_clk);
        output_on <= 1'b0;
        tick(2);
        end_of_test();
    end
endmodule // testbench

bind lss_list_step_sequencer lss_seq_props u_props (.ref_clk, .rst_n, .output_on,
    .start_local, .end_zero, .src, .running, .measuring, .dio2_out, .step_idx,
    .cycle_idx, .trig_src_eff, .trig_count, .arm_count, .init_cont);

`default_nettype wire
